// *** core/sia_ctrl.v ***
`include "sia_ctrl_map.vh"
`default_nettype none
module sia_ctrl #(
  parameter integer UNIT_TEN_SHORT  = `UNIT_TEN_SHORT_PS / `CLK_PERIOD_PS,
  parameter integer UNIT_FAST_SHORT = `UNIT_FAST_SHORT_PS / `CLK_PERIOD_PS,
  parameter integer UNIT_MII_SHORT  = `UNIT_MII10_SHORT_PS / `CLK_PERIOD_PS,
  parameter integer UNIT_TEN_LONG   = `UNIT_TEN_LONG_PS / `CLK_PERIOD_PS,
  parameter integer UNIT_FAST_LONG  = `UNIT_FAST_LONG_PS / `CLK_PERIOD_PS
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire        soft_reset_i,
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [31:0] rdata_o,
  input  wire [1:0]  media_mode_i,
  input  wire        mii_selected_i,
  input  wire        mii_rx_act_i,
  input  wire        aui_rx_act_i,
  input  wire        tp_rx_act_i,
  input  wire        signal_detect_i,
  input  wire        pcs_enable_i,
  input  wire        tp_link_ok_i,
  input  wire        polarity_pos_i,
  input  wire        unstable_pulses_i,
  input  wire [2:0]  arb_state_i,
  input  wire        partner_negotiable_i,
  input  wire [15:0] partner_word_i,
  input  wire        gen_port_event_i,
  input  wire        rx_packet_i,
  input  wire        tx_packet_i,
  input  wire        rx_bit_i,
  output reg         irq_o,
  output reg         rx_irq_o,
  output reg         tx_irq_o,
  output reg         rx_bit_o,
  output reg         sia_reset_o,
  output reg         aui_select_o,
  output reg         negotiation_restart_o,
  output reg  [15:0] tx_code_word_o,
  output reg         tx_encoder_enable_o,
  output reg         internal_loopback_o,
  output reg         tx_driver_enable_o,
  output reg         link_pulse_gen_enable_o,
  output reg  [1:0]  compensation_mode_o,
  output reg         negotiation_enable_o,
  output reg         rx_tp_enable_o,
  output reg         rx_aui_enable_o,
  output reg         collision_squelch_enable_o,
  output reg         collision_detect_enable_o,
  output reg         heartbeat_generate_o,
  output reg         port_autosense_enable_o,
  output reg         tx_allowed_o,
  output reg         rx_allowed_o
);
  // Media modes: 0 serial 10 Mb/s, 1 MII/symbol 100 Mb/s, 2 MII 10 Mb/s
  localparam [1:0] MODE_SERIAL = 2'h0;
  localparam [1:0] MODE_FAST   = 2'h1;
  localparam [1:0] MODE_MII10  = 2'h2;

  // Two-flop synchronisers for the pin-side levels
  localparam integer NSYNC = 9;
  wire [NSYNC-1:0] async_in = {mii_rx_act_i, aui_rx_act_i, tp_rx_act_i, signal_detect_i,
                               tp_link_ok_i, polarity_pos_i, unstable_pulses_i,
                               partner_negotiable_i, rx_bit_i};
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
        end else begin
          sync1_reg[g] <= async_in[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate
  wire s_mii_act  = sync2_reg[8];
  wire s_aui_act  = sync2_reg[7];
  wire s_tp_act   = sync2_reg[6];
  wire s_sd       = sync2_reg[5];
  wire s_tp_ok    = sync2_reg[4];
  wire s_pol_pos  = sync2_reg[3];
  wire s_unstable = sync2_reg[2];
  wire s_partner  = sync2_reg[1];
  wire s_rx_bit   = sync2_reg[0];

  reg  [31:0] irq_enable_reg;
  reg  [31:0] mitigation_reg;
  reg  [31:0] connect_reg;
  reg  [31:0] txrx_reg;
  reg  [31:0] irq_status_reg;
  reg  [2:0]  act_reg;
  reg         unstable_reg;
  reg         remote_fault_reg;
  reg  [2:0]  arb_reg;
  reg         partner_reg;
  reg  [15:0] partner_word_reg;
  reg         tp_fail_q_reg;
  reg         arb_done_q_reg;

  wire wr_hit_enable  = wr_i && (addr_i == `OFS_IRQ_ENABLE);
  wire wr_hit_mit     = wr_i && (addr_i == `OFS_MITIGATION);
  wire wr_hit_status  = wr_i && (addr_i == `OFS_SIA_STATUS);
  wire wr_hit_connect = wr_i && (addr_i == `OFS_SIA_CONNECT);
  wire wr_hit_txrx    = wr_i && (addr_i == `OFS_SIA_TXRX);
  wire wr_hit_irqst   = wr_i && (addr_i == `OFS_LINK_IRQ_STAT);
  wire rd_hit_status  = rd_i && (addr_i == `OFS_SIA_STATUS);

  wire sia_held    = ~connect_reg[0];
  wire neg_en      = txrx_reg[7] && !connect_reg[3];
  wire link_test_en = txrx_reg[12];
  wire tp_fail     = link_test_en && !s_tp_ok;
  wire arb_good    = (arb_reg == `ARB_LINK_GOOD);
  wire fast_fail   = pcs_enable_i && !s_sd && (!neg_en || arb_good);
  wire auto_pol    = txrx_reg[13] && txrx_reg[12];
  wire pol_pos     = auto_pol ? s_pol_pos : txrx_reg[14];

  // Status events
  wire ev_link_fail = tp_fail && !tp_fail_q_reg && !connect_reg[3];
  wire ev_link_pass = (!tp_fail && tp_fail_q_reg && !neg_en) ||
                      (neg_en && arb_good && !arb_done_q_reg);
  wire ev_link_chg  = tp_fail != tp_fail_q_reg;

  // Mitigation timing
  reg  [31:0] unit_cycles;
  always @* begin
    case ({mitigation_reg[`BIT_CYCLE_SIZE], media_mode_i})
      {1'b1, MODE_SERIAL}: unit_cycles = UNIT_TEN_SHORT;
      {1'b1, MODE_FAST}:   unit_cycles = UNIT_FAST_SHORT;
      {1'b1, MODE_MII10}:  unit_cycles = UNIT_MII_SHORT;
      {1'b0, MODE_FAST}:   unit_cycles = UNIT_FAST_LONG;
      default:             unit_cycles = UNIT_TEN_LONG;
    endcase
  end

  reg  [31:0] rx_pre_reg;
  reg  [31:0] tx_pre_reg;
  reg  [3:0]  rx_units_reg;
  reg  [7:0]  tx_units_reg;
  reg  [2:0]  rx_cnt_reg;
  reg  [2:0]  tx_cnt_reg;
  reg         rx_pend_reg;
  reg         tx_pend_reg;
  wire [2:0]  rx_lim = mitigation_reg[19:17];
  wire [3:0]  rx_tim = mitigation_reg[23:20];
  wire [2:0]  tx_lim = mitigation_reg[26:24];
  wire [3:0]  tx_tim = mitigation_reg[30:27];
  wire rx_mit_off = (rx_lim == 3'h0) && (rx_tim == 4'h0);
  wire tx_mit_off = (tx_lim == 3'h0) && (tx_tim == 4'h0);
  wire rx_unit_tick = rx_pre_reg >= unit_cycles - 32'h1;
  wire tx_unit_tick = tx_pre_reg >= unit_cycles - 32'h1;
  wire rx_fire = rx_mit_off ? rx_packet_i :
                 (rx_packet_i && rx_lim != 3'h0 && rx_cnt_reg + 3'h1 >= rx_lim) ||
                 (rx_pend_reg && rx_tim != 4'h0 && rx_unit_tick && rx_units_reg + 4'h1 >= rx_tim);
  wire tx_fire = tx_mit_off ? tx_packet_i :
                 (tx_packet_i && tx_lim != 3'h0 && tx_cnt_reg + 3'h1 >= tx_lim) ||
                 (tx_pend_reg && tx_tim != 4'h0 && tx_unit_tick &&
                  tx_units_reg + 8'h1 >= {tx_tim, 4'h0});

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_pre_reg <= 32'h0; rx_units_reg <= 4'h0; rx_cnt_reg <= 3'h0; rx_pend_reg <= 1'b0;
      tx_pre_reg <= 32'h0; tx_units_reg <= 8'h0; tx_cnt_reg <= 3'h0; tx_pend_reg <= 1'b0;
    end else if (soft_reset_i || rx_fire || tx_fire) begin
      if (soft_reset_i || rx_fire) begin
        rx_pre_reg <= 32'h0; rx_units_reg <= 4'h0; rx_cnt_reg <= 3'h0; rx_pend_reg <= 1'b0;
      end
      if (soft_reset_i || tx_fire) begin
        tx_pre_reg <= 32'h0; tx_units_reg <= 8'h0; tx_cnt_reg <= 3'h0; tx_pend_reg <= 1'b0;
      end
    end else begin
      if (rx_packet_i) begin
        rx_cnt_reg  <= rx_cnt_reg + 3'h1;
        rx_pend_reg <= 1'b1;
      end
      if (rx_pend_reg) begin
        rx_pre_reg <= rx_unit_tick ? 32'h0 : rx_pre_reg + 32'h1;
        if (rx_unit_tick) rx_units_reg <= rx_units_reg + 4'h1;
      end
      if (tx_packet_i) begin
        tx_cnt_reg  <= tx_cnt_reg + 3'h1;
        tx_pend_reg <= 1'b1;
      end
      if (tx_pend_reg) begin
        tx_pre_reg <= tx_unit_tick ? 32'h0 : tx_pre_reg + 32'h1;
        if (tx_unit_tick) tx_units_reg <= tx_units_reg + 8'h1;
      end
    end
  end

  // Register writes and status
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_enable_reg   <= 32'h0;
      mitigation_reg   <= 32'h0;
      connect_reg      <= `RESET_CONNECT;
      txrx_reg         <= `RESET_TXRX;
      irq_status_reg   <= 32'h0;
      act_reg          <= 3'h0;
      unstable_reg     <= 1'b0;
      remote_fault_reg <= 1'b0;
      arb_reg          <= `ARB_DISABLED;
      partner_reg      <= 1'b0;
      partner_word_reg <= 16'h0;
      tp_fail_q_reg    <= 1'b0;
      arb_done_q_reg   <= 1'b0;
      negotiation_restart_o <= 1'b0;
    end else if (soft_reset_i) begin
      irq_enable_reg   <= 32'h0;
      mitigation_reg   <= 32'h0;
      connect_reg      <= `RESET_CONNECT;
      txrx_reg         <= `RESET_TXRX;
      irq_status_reg   <= 32'h0;
      act_reg          <= 3'h0;
      unstable_reg     <= 1'b0;
      remote_fault_reg <= 1'b0;
      arb_reg          <= `ARB_DISABLED;
      partner_reg      <= 1'b0;
      partner_word_reg <= 16'h0;
      tp_fail_q_reg    <= 1'b0;
      arb_done_q_reg   <= 1'b0;
      negotiation_restart_o <= 1'b0;
    end else begin
      if (wr_hit_enable)  irq_enable_reg <= wdata_i;
      if (wr_hit_mit)     mitigation_reg <= wdata_i;
      if (wr_hit_connect) connect_reg    <= wdata_i;
      if (wr_hit_txrx)    txrx_reg       <= wdata_i;
      tp_fail_q_reg  <= tp_fail;
      arb_done_q_reg <= neg_en && arb_good;
      // Set beats a simultaneous write-one clear
      act_reg[0] <= (act_reg[0] && !(wr_hit_status && wdata_i[0])) ||
                    (s_mii_act && mii_selected_i);
      act_reg[1] <= (act_reg[1] && !(wr_hit_status && wdata_i[8])) || s_aui_act;
      act_reg[2] <= (act_reg[2] && !(wr_hit_status && wdata_i[9])) || s_tp_act;
      unstable_reg <= (unstable_reg && !rd_hit_status) ||
                      (neg_en && s_unstable);
      if (wr_hit_status) remote_fault_reg <= wdata_i[11];
      negotiation_restart_o <= wr_hit_status && neg_en &&
                               (wdata_i[14:12] == `ARB_TRANS_DISABLE);
      arb_reg     <= (sia_held || !neg_en) ? `ARB_DISABLED : arb_state_i;
      partner_reg <= neg_en && s_partner;
      if (neg_en && s_partner) partner_word_reg <= partner_word_i;
      begin : irq_status_update
        reg [31:0] nxt;
        nxt = irq_status_reg;
        if (wr_hit_irqst) nxt = nxt & ~wdata_i;
        if (ev_link_pass) begin
          nxt[`BIT_LINK_PASS] = 1'b1;
          nxt[`BIT_LINK_FAIL] = 1'b0;
        end
        if (ev_link_fail) begin
          nxt[`BIT_LINK_FAIL] = 1'b1;
          nxt[`BIT_LINK_PASS] = 1'b0;
        end
        if (wr_hit_txrx && !wdata_i[12]) nxt[`BIT_LINK_PASS] = 1'b1;
        if (ev_link_chg) nxt[`BIT_LINK_CHANGED] = 1'b1;
        if (gen_port_event_i) nxt[`BIT_GEN_PORT] = 1'b1;
        if (rx_fire) nxt[`BIT_RX_DONE] = 1'b1;
        if (tx_fire) nxt[`BIT_TX_DONE] = 1'b1;
        irq_status_reg <= nxt;
      end
    end
  end

  // Read data, one cycle after the strobe
  wire [31:0] status_word = {partner_word_reg, partner_reg, arb_reg, remote_fault_reg,
                             unstable_reg, act_reg[2], act_reg[1], 4'h0, pol_pos,
                             tp_fail, fast_fail, act_reg[0]};
  reg  [31:0] rdata_next;
  always @* begin
    case (addr_i)
      `OFS_IRQ_ENABLE:    rdata_next = irq_enable_reg;
      `OFS_MITIGATION:    rdata_next = mitigation_reg;
      `OFS_SIA_STATUS:    rdata_next = status_word;
      `OFS_SIA_CONNECT:   rdata_next = connect_reg;
      `OFS_SIA_TXRX:      rdata_next = txrx_reg;
      `OFS_LINK_IRQ_STAT: rdata_next = irq_status_reg;
      default:            rdata_next = 32'h0;
    endcase
  end

  wire [31:0] gated = irq_status_reg & irq_enable_reg;
  wire irq_next = irq_enable_reg[`BIT_ABN_SUMMARY] &&
                  (gated[`BIT_LINK_PASS] || gated[`BIT_LINK_FAIL] ||
                   gated[`BIT_GEN_PORT] || gated[`BIT_LINK_CHANGED]);

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 32'h0; irq_o <= 1'b0; rx_irq_o <= 1'b0; tx_irq_o <= 1'b0;
      rx_bit_o <= 1'b0; sia_reset_o <= 1'b1; aui_select_o <= 1'b0;
      tx_code_word_o <= 16'h0; tx_encoder_enable_o <= 1'b0; internal_loopback_o <= 1'b0;
      tx_driver_enable_o <= 1'b0; link_pulse_gen_enable_o <= 1'b0;
      compensation_mode_o <= 2'h0; negotiation_enable_o <= 1'b0; rx_tp_enable_o <= 1'b0;
      rx_aui_enable_o <= 1'b0; collision_squelch_enable_o <= 1'b0;
      collision_detect_enable_o <= 1'b0; heartbeat_generate_o <= 1'b0;
      port_autosense_enable_o <= 1'b0; tx_allowed_o <= 1'b0; rx_allowed_o <= 1'b0;
    end else begin
      rdata_o  <= rd_i ? rdata_next : 32'h0;
      irq_o    <= irq_next;
      rx_irq_o <= rx_fire;
      tx_irq_o <= tx_fire;
      rx_bit_o <= pol_pos ? s_rx_bit : ~s_rx_bit;
      sia_reset_o  <= sia_held;
      aui_select_o <= connect_reg[3];
      tx_code_word_o <= {2'h0, remote_fault_reg, 3'h0, txrx_reg[18:16], 1'b0,
                         txrx_reg[6], 5'h01};
      tx_encoder_enable_o     <= txrx_reg[0] && !sia_held;
      internal_loopback_o     <= txrx_reg[1] && !sia_held;
      tx_driver_enable_o      <= txrx_reg[2] && !sia_held;
      link_pulse_gen_enable_o <= txrx_reg[3] && !connect_reg[3] && !sia_held;
      compensation_mode_o     <= txrx_reg[5] ? txrx_reg[5:4] : 2'h0;
      negotiation_enable_o    <= neg_en && !sia_held;
      rx_tp_enable_o  <= txrx_reg[8] && !sia_held && (!connect_reg[3] || neg_en);
      rx_aui_enable_o <= txrx_reg[8] && !sia_held && (connect_reg[3] || neg_en);
      collision_squelch_enable_o <= txrx_reg[9] && !sia_held;
      collision_detect_enable_o  <= txrx_reg[10] && !sia_held;
      heartbeat_generate_o       <= txrx_reg[11] && !sia_held;
      port_autosense_enable_o    <= txrx_reg[15] && !sia_held;
      tx_allowed_o <= !sia_held && !(tp_fail && !connect_reg[3]);
      rx_allowed_o <= !sia_held && !(tp_fail && !connect_reg[3]);
    end
  end
endmodule // sia_ctrl
`default_nettype wire

// *** shared/sia_ctrl_map.vh ***
`ifndef SIA_CTRL_MAP_VH
`define SIA_CTRL_MAP_VH
`define OFS_IRQ_ENABLE     8'h38
`define OFS_MITIGATION     8'h58
`define OFS_SIA_STATUS     8'h60
`define OFS_SIA_CONNECT    8'h68
`define OFS_SIA_TXRX       8'h70
`define OFS_LINK_IRQ_STAT  8'h28
`define BIT_LINK_PASS      4
`define BIT_LINK_FAIL      12
`define BIT_ABN_SUMMARY    15
`define BIT_GEN_PORT       26
`define BIT_LINK_CHANGED   27
`define BIT_RX_DONE        0
`define BIT_TX_DONE        1
`define BIT_CYCLE_SIZE     31
`define ARB_DISABLED       3'h0
`define ARB_TRANS_DISABLE  3'h1
`define ARB_ABILITY        3'h2
`define ARB_ACK_DETECT     3'h3
`define ARB_COMPLETE_ACK   3'h4
`define ARB_LINK_GOOD      3'h5
`define ARB_LINK_CHECK     3'h6
`define CLK_PERIOD_PS      10000
`define UNIT_TEN_SHORT_PS  12800000
`define UNIT_FAST_SHORT_PS 5120000
`define UNIT_MII10_SHORT_PS 51200000
`define UNIT_TEN_LONG_PS   204800000
`define UNIT_FAST_LONG_PS  81920000
`define RESET_TXRX         32'h0000_0000
`define RESET_CONNECT      32'h0000_0000
`endif

// *** verif/link_partner_model.sv ***
`default_nettype none
module link_partner_model (
  input  wire logic       clk_i,
  input  wire logic       link_up_i,
  input  wire logic       reversed_i,
  input  wire logic [2:0] burst_i,
  input  wire logic       sending_i,
  input  wire logic       data_i,
  output logic      [2:0] act_o,
  output logic            link_ok_o,
  output logic            polarity_pos_o,
  output logic            line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] left [3] = '{3'd0, 3'd0, 3'd0};
  logic       idle_bit = 1'b0;
  // Activity per port lasts four cycles so the two-flop sync sees it
  always @(posedge clk_i) begin
    idle_bit <= ~idle_bit;
    for (int p = 0; p < 3; p++) begin
      if (burst_i[p]) left[p] <= 3'd4;
      else if (left[p] != 3'd0) left[p] <= left[p] - 3'd1;
    end
  end
  always_comb begin
    for (int p = 0; p < 3; p++) act_o[p] = left[p] != 3'd0;
  end
  assign link_ok_o = link_up_i;
  assign polarity_pos_o = !reversed_i;
  // Swapped pair inverts the wire; a released line toggles
  assign line_o = sending_i ? data_i ^ reversed_i : idle_bit;
endmodule // link_partner_model
`default_nettype wire

// *** verif/sia_ctrl_checker.sv ***
`default_nettype none
module sia_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  input wire logic        soft_reset_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        irq_o,
  input wire logic        sia_reset_o,
  input wire logic        aui_select_o,
  input wire logic        negotiation_restart_o,
  input wire logic [15:0] tx_code_word_o,
  input wire logic        tx_encoder_enable_o,
  input wire logic        internal_loopback_o,
  input wire logic        tx_driver_enable_o,
  input wire logic        link_pulse_gen_enable_o,
  input wire logic [1:0]  compensation_mode_o,
  input wire logic        negotiation_enable_o,
  input wire logic        heartbeat_generate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] en_reg;
  logic        quiet;
  logic        restart_req;
  assign quiet = !rd_i || !(addr_i inside {8'h28, 8'h38, 8'h58, 8'h60, 8'h68, 8'h70});
  assign restart_req = wr_i && addr_i == 8'h60 && wdata_i[14:12] == 3'h1;
  // Shadow of the interrupt enable register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) en_reg <= 32'h0;
    else if (soft_reset_i) en_reg <= 32'h0;
    else if (wr_i && addr_i == 8'h38) en_reg <= wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence wr_at(logic [7:0] a);
    wr_i && addr_i == a && !soft_reset_i;
  endsequence
  sequence cleared;
    sia_reset_o && !negotiation_enable_o && !heartbeat_generate_o;
  endsequence
  rdata_quiet_a: assert property ($past(quiet) |-> rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  // Register update, then registered output: visible two edges after the write
  sia_hold_a: assert property (wr_at(8'h68) |=> ##1
    sia_reset_o == !$past(wdata_i[0], 2) && aui_select_o == $past(wdata_i[3], 2))
    else $error("connectivity write not reflected");
  tx_enables_a: assert property (wr_at(8'h70) |=> ##1
    {link_pulse_gen_enable_o, tx_driver_enable_o, internal_loopback_o,
     tx_encoder_enable_o} == ($past(wdata_i[3:0], 2) & {!aui_select_o, 3'h7}))
    else $error("enable bits wrong");
  comp_mode_a: assert property (wr_at(8'h70) |=> ##1
    compensation_mode_o == ($past(wdata_i[5], 2) ? $past(wdata_i[5:4], 2) : 2'h0))
    else $error("compensation mode wrong");
  heartbeat_copy_a: assert property (wr_at(8'h70) |=> ##1
    heartbeat_generate_o == $past(wdata_i[11], 2)) else $error("heartbeat enable wrong");
  code_adv_a: assert property (wr_at(8'h70) ##0 wdata_i[7] |=> ##1
    tx_code_word_o[9:7] == $past(wdata_i[18:16], 2) &&
    tx_code_word_o[5] == $past(wdata_i[6], 2))
    else $error("advertised abilities wrong");
  restart_cause_a: assert property (negotiation_restart_o |-> $past(restart_req))
    else $error("restart pulse without request");
  restart_go_a: assert property (wr_at(8'h60) ##0
    (wdata_i[14:12] == 3'h1 && negotiation_enable_o) |=> negotiation_restart_o)
    else $error("restart request ignored");
  irq_masked_a: assert property (en_reg == 32'h0 && $past(en_reg) == 32'h0 |-> !irq_o)
    else $error("interrupt with all enables clear");
  soft_clear_a: assert property (soft_reset_i |=> ##1 cleared)
    else $error("soft reset left state behind");
endmodule // sia_ctrl_checker
bind sia_ctrl sia_ctrl_checker u_sia_ctrl_checker (.*);
`default_nettype wire

// *** verif/test_sia_ctrl.sv ***
`default_nettype none
module test_sia_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, arst_n_i = 1'b0, soft_reset_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [1:0] media_mode_i = 2'h0, compensation_mode_o;
  logic [2:0] arb_state_i = 3'h0, burst = 3'h0;
  logic [15:0] partner_word_i = 16'h0, tx_code_word_o;
  logic mii_selected_i = 1'b0, pcs_enable_i = 1'b1, unstable_pulses_i = 1'b0;
  logic partner_negotiable_i = 1'b0, gen_port_event_i = 1'b0, rx_packet_i = 1'b0;
  logic tx_packet_i = 1'b0, link_up = 1'b1, reversed = 1'b0, sending = 1'b0, data_bit = 1'b0;
  wire mii_rx_act_i, aui_rx_act_i, tp_rx_act_i, signal_detect_i, tp_link_ok_i;
  wire polarity_pos_i, rx_bit_i;
  logic irq_o, rx_irq_o, tx_irq_o, rx_bit_o, sia_reset_o, aui_select_o, negotiation_restart_o;
  logic tx_encoder_enable_o, internal_loopback_o, tx_driver_enable_o, link_pulse_gen_enable_o;
  logic negotiation_enable_o, rx_tp_enable_o, rx_aui_enable_o, collision_squelch_enable_o;
  logic collision_detect_enable_o, heartbeat_generate_o, port_autosense_enable_o;
  logic tx_allowed_o, rx_allowed_o;
  int fails = 0, checks_done = 0, cycles = 0;
  sia_ctrl #(.UNIT_TEN_SHORT(4), .UNIT_FAST_SHORT(8), .UNIT_MII_SHORT(12),
    .UNIT_TEN_LONG(16), .UNIT_FAST_LONG(24)) u_sia_ctrl (.*);
  link_partner_model u_link_partner_model (
    .clk_i          (clk_i),
    .link_up_i      (link_up),
    .reversed_i     (reversed),
    .burst_i        (burst),
    .sending_i      (sending),
    .data_i         (data_bit),
    .act_o          ({tp_rx_act_i, aui_rx_act_i, mii_rx_act_i}),
    .link_ok_o      (tp_link_ok_i),
    .polarity_pos_o (polarity_pos_i),
    .line_o         (rx_bit_i)
  );
  assign signal_detect_i = tp_link_ok_i;
  initial forever #5 clk_i = ~clk_i;
  task automatic results;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chkrd(input logic [7:0] a, input logic [31:0] m, e, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e, what);
  endtask
  task automatic pkt(input bit tx);
    @(posedge clk_i);
    if (tx) tx_packet_i <= 1'b1;
    else rx_packet_i <= 1'b1;
    @(posedge clk_i);
    tx_packet_i <= 1'b0;
    rx_packet_i <= 1'b0;
  endtask
  task automatic wait_irq(input bit tx, input int lim, output int n);
    n = -1;
    for (int i = 1; i <= lim && n < 0; i++) begin
      @(negedge clk_i);
      if ((tx ? tx_irq_o : rx_irq_o) === 1'b1) n = i;
    end
  endtask
  task automatic t_reset_values;
    logic [7:0] regs [5] = '{8'h38, 8'h58, 8'h68, 8'h70, 8'h7c};
    foreach (regs[i]) chkrd(regs[i], 32'hffff_ffff, 32'h0, "reset value");
    chkrd(8'h60, 32'h0000_f700, 32'h0, "idle status");
    chk(sia_reset_o, 1'b1, "serial logic held");
    $display("test reset_values done");
  endtask
  task automatic t_config;
    wr(8'h68, 32'h9);
    @(posedge clk_i);
    #1 chk({sia_reset_o, aui_select_o}, 2'b01, "aui select");
    for (int c = 0; c < 4; c++) begin
      wr(8'h70, 32'h0000_088f | (c << 4));
      @(posedge clk_i);
      // Link pulses stay off on AUI; codes 00 and 01 both disable compensation
      #1 chk({heartbeat_generate_o, compensation_mode_o, link_pulse_gen_enable_o,
        tx_driver_enable_o, internal_loopback_o, tx_encoder_enable_o},
        32'h47 | ((c > 1 ? c : 0) << 4), "tx rx config");
      chk(negotiation_enable_o, 1'b0, "no negotiation on aui");
      chkrd(8'h70, 32'hffff_ffff, 32'h0000_088f | (c << 4), "config readback");
    end
    $display("test config done");
  endtask
  task automatic t_activity;
    wr(8'h68, 32'h1);
    mii_selected_i <= 1'b1;
    burst <= 3'b111;
    @(posedge clk_i);
    burst <= 3'b000;
    repeat (8) @(posedge clk_i);
    chkrd(8'h60, 32'h301, 32'h301, "activity set");
    wr(8'h60, 32'h301);
    chkrd(8'h60, 32'h301, 32'h0, "activity cleared");
    $display("test activity done");
  endtask
  task automatic t_link_irq;
    wr(8'h70, 32'h1100);
    repeat (10) @(posedge clk_i);
    wr(8'h28, 32'hffff_ffff);
    wr(8'h38, 32'h1000);
    link_up <= 1'b0;
    repeat (10) @(posedge clk_i);
    chkrd(8'h28, 32'h1010, 32'h1000, "fail event");
    chk(irq_o, 1'b0, "fail masked by summary");
    chkrd(8'h60, 32'h4, 32'h4, "tp link fail");
    chk({tx_allowed_o, rx_allowed_o}, 2'b00, "traffic blocked");
    wr(8'h38, 32'h9000);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1'b1, "fail interrupt");
    chkrd(8'h28, 32'h1000, 32'h1000, "held after read");
    link_up <= 1'b1;
    repeat (10) @(posedge clk_i);
    chkrd(8'h28, 32'h10, 32'h10, "pass event");
    link_up <= 1'b0;
    repeat (10) @(posedge clk_i);
    chkrd(8'h28, 32'h1010, 32'h1000, "pass cleared by fail");
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    link_up <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0, "irq after soft reset");
    chkrd(8'h38, 32'hffff_ffff, 32'h0, "enables after soft reset");
    $display("test link_irq done");
  endtask
  task automatic t_mitig;
    int n;
    int u;
    wr(8'h58, 32'h0004_0000);
    pkt(0);
    wait_irq(0, 10, n);
    chk(n, -1, "early rx irq");
    pkt(0);
    wait_irq(0, 4, n);
    chk(n > 0, 1, "rx irq on count");
    for (int m = 0; m < 3; m++)
      for (int cs = 0; cs < 2; cs++) if (m < 2 || cs) begin
        media_mode_i <= m[1:0];
        wr(8'h58, {cs[0], 4'h0, 3'h0, 4'h1, 3'h7, 17'h0});
        u = cs ? (m == 0 ? 4 : m == 1 ? 8 : 12) : (m == 0 ? 16 : 24);
        pkt(0);
        wait_irq(0, 40, n);
        chk(n >= u - 1 && n <= u + 3, 1, "rx timer");
      end
    media_mode_i <= 2'h0;
    wr(8'h58, 32'h8f00_0000);
    for (int k = 0; k < 2; k++) begin
      pkt(1);
      wait_irq(1, 100, n);
      chk(n >= 63 && n <= 67, 1, "tx timer");
    end
    wr(8'h58, 32'h0);
    pkt(0);
    wait_irq(0, 3, n);
    chk(n > 0, 1, "unmitigated rx irq");
    $display("test mitigation done");
  endtask
  task automatic t_polarity;
    wr(8'h68, 32'h1);
    wr(8'h70, 32'h3100);
    for (int r = 0; r < 2; r++)
      for (int b = 0; b < 2; b++) begin
        reversed <= r[0];
        data_bit <= b[0];
        sending <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk(rx_bit_o, b[0], "corrected bit");
        chkrd(8'h60, 32'h8, r ? 32'h0 : 32'h8, "polarity");
      end
    sending <= 1'b0;
    $display("test polarity done");
  endtask
  task automatic t_negotiation;
    wr(8'h70, 32'h0005_01c0);
    partner_negotiable_i <= 1'b1;
    partner_word_i <= 16'h4de1;
    for (int s = 0; s < 7; s++) begin
      arb_state_i <= s[2:0];
      repeat (4) @(posedge clk_i);
      chkrd(8'h60, 32'hffff_f000, {16'h4de1, 1'b1, s[2:0], 12'h0}, "arbitration");
    end
    chk({negotiation_enable_o, rx_tp_enable_o, rx_aui_enable_o}, 3'h7, "receivers");
    wr(8'h60, 32'h1800);
    #1 chk(negotiation_restart_o, 1'b1, "restart");
    repeat (2) @(posedge clk_i);
    chk(tx_code_word_o, 16'h22a1, "code word");
    unstable_pulses_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    unstable_pulses_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chkrd(8'h60, 32'h400, 32'h400, "unstable pulses");
    chkrd(8'h60, 32'h400, 32'h0, "cleared by read");
    wr(8'h70, 32'h100);
    wr(8'h60, 32'h1000);
    #1 chk(negotiation_restart_o, 1'b0, "no restart when disabled");
    $display("test negotiation done");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset_values();
    t_config();
    t_activity();
    t_link_irq();
    t_mitig();
    t_polarity();
    t_negotiation();
    results();
  end
endmodule // test_sia_ctrl
`default_nettype wire
